// [irq_status.sv]
// interrupt status, mask and acknowledge logic of the ethernet controller
// assumes event inputs synchronous to aclk
// Operation
// - mask bit high enables its status source onto the interrupt output
// - mask register accepted as word or as byte access
// - change of any monitored phy bit not already held sets phy change flag
// - phy bits latch on change; read refreshes them
// - phy change flag clears only by acknowledge write of its bit
// - early receive set above byte threshold, held until acknowledged
// - handler flag merges three individually enabled exceptions
// - fatal error clears transmit enable and success, records cause
// - handler flag clears only through its cause
// - receive overrun set on allocation failure, oversize frame or discard
// - overrun flag stays latched until acknowledge write with its bit
// - allocation flag is inverse of allocation failed
// - allocation flag clears on next request or failed allocation
// - queue empty flag latched on becoming empty until acknowledged
// - transmit complete flag is inverse of completion queue empty
// - transmit complete acknowledge pops that packet's completion
// - receive pending is inverse of receive queue empty
// - write-only acknowledge at status offset; ones clear flags
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
module irq_status #(
    parameter int AW = 8
) (
    // clock and reset
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    // axi4-lite slave
    input  wire logic [AW-1:0]                s_axi_awaddr,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    input  wire logic [AW-1:0]                s_axi_araddr,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    output logic [31:0]                       s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    // device events
    input  wire logic [irq_status_pkg::PHY_BITS-1:0] phy_status,
    input  wire irq_status_pkg::rx_ev_t       rx_ev,
    input  wire logic                         link_transition,
    input  wire logic                         counter_rollover,
    input  wire logic [15:0]                  counter_value,
    input  wire logic                         tx_done,
    input  wire logic                         tx_fatal,
    input  wire irq_status_pkg::tx_cause_t    tx_cause,
    input  wire logic                         alloc_request,
    input  wire logic                         alloc_ok,
    input  wire logic                         alloc_fail,
    input  wire logic                         tx_queue_empty,
    input  wire logic                         completion_queue_empty,
    input  wire logic                         receive_queue_empty,
    // outputs to the device
    output logic                              irq,
    output logic                              transmit_enable_flag,
    output logic                              receive_discard,
    output logic                              completion_pop
);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:0]                  interrupt_enable_mask_q;
    logic                        phy_mgmt_change_irq_q;
    logic                        early_receive_irq_q;
    logic                        receive_overrun_irq_q;
    logic                        tx_empty_irq_q;
    logic                        tx_empty_prev_q;
    logic                        alloc_failed_q;
    logic                        link_pend_q;
    logic                        roll_pend_q;
    logic                        txerr_pend_q;
    logic                        txen_q;
    logic                        tx_success_q;
    irq_status_pkg::tx_cause_t   cause_q;
    logic                        le_en_q;
    logic                        cr_en_q;
    logic                        te_en_q;
    logic                        discard_q;
    logic [irq_status_pkg::THR_W-1:0] early_receive_threshold_q;
    logic [irq_status_pkg::PHY_BITS-1:0] phy_lat_q;
    logic [irq_status_pkg::PHY_BITS-1:0] phy_held_q;
    logic                        pop_q;
    logic                        irq_q;

    // bus handshake state
    logic                        awready_q;
    logic                        arready_q;
    logic                        bvalid_q;
    logic                        rvalid_q;
    logic [1:0]                  bresp_q;
    logic [1:0]                  rresp_q;
    logic [31:0]                 rdata_q;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [AW-1:0] a, input logic [5:0] idx);
        hit = (a[AW-1:2] == (AW-2)'(idx));
    endfunction

    logic       wr_go;
    logic       rd_go;
    logic [7:0] status;
    logic [7:0] ack;
    logic       wr_ctl;
    logic       rd_phy;
    logic       rd_cnt;
    logic       ph_irq;
    logic       early_hit;

    // write taken with address and data together, no answer waiting
    assign wr_go  = s_axi_awvalid & s_axi_wvalid & ~awready_q & ~bvalid_q;
    assign rd_go  = s_axi_arvalid & ~arready_q & ~rvalid_q;
    assign wr_ctl = wr_go & hit(s_axi_awaddr, irq_status_pkg::IDX_CONTROL) & s_axi_wstrb[0];
    assign rd_phy = rd_go & hit(s_axi_araddr, irq_status_pkg::IDX_PHY_ST);
    assign rd_cnt = rd_go & hit(s_axi_araddr, irq_status_pkg::IDX_COUNTER);
    // write-only acknowledge shares the status offset
    assign ack    = (wr_go & hit(s_axi_awaddr, irq_status_pkg::IDX_STATUS) & s_axi_wstrb[0])
                    ? s_axi_wdata[7:0] : 8'h00;

    // merged protocol handler exceptions
    assign ph_irq = link_pend_q | roll_pend_q | txerr_pend_q;

    // stored bytes above threshold of 64-byte blocks
    assign early_hit = rx_ev.active &
        (rx_ev.bytes > (irq_status_pkg::RX_BYTES_W)'({early_receive_threshold_q,
                                                      {irq_status_pkg::THR_SHIFT{1'b0}}}));

    // status byte as software sees it
    always_comb begin
        status = 8'h00;
        status[irq_status_pkg::B_MGMT]  = phy_mgmt_change_irq_q;
        status[irq_status_pkg::B_ERCV]  = early_receive_irq_q;
        status[irq_status_pkg::B_PH]    = ph_irq;
        status[irq_status_pkg::B_OVRN]  = receive_overrun_irq_q;
        status[irq_status_pkg::B_ALLOC] = ~alloc_failed_q;
        status[irq_status_pkg::B_TXEMP] = tx_empty_irq_q;
        status[irq_status_pkg::B_TXCMP] = ~completion_queue_empty;
        status[irq_status_pkg::B_RCV]   = ~receive_queue_empty;
    end

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= irq_status_pkg::RESP_OKAY;
        end else begin
            awready_q <= wr_go;
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q  <= (hit(s_axi_awaddr, irq_status_pkg::IDX_STATUS)  |
                             hit(s_axi_awaddr, irq_status_pkg::IDX_MASK)    |
                             hit(s_axi_awaddr, irq_status_pkg::IDX_CONTROL) |
                             hit(s_axi_awaddr, irq_status_pkg::IDX_PH_STAT) |
                             hit(s_axi_awaddr, irq_status_pkg::IDX_PHY_ST)  |
                             hit(s_axi_awaddr, irq_status_pkg::IDX_COUNTER))
                            ? irq_status_pkg::RESP_OKAY : irq_status_pkg::RESP_DECERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rresp_q   <= irq_status_pkg::RESP_OKAY;
            rdata_q   <= 32'h0000_0000;
        end else begin
            arready_q <= rd_go;
            if (rd_go) begin
                rvalid_q <= 1'b1;
                rresp_q  <= irq_status_pkg::RESP_OKAY;
                rdata_q  <= 32'h0000_0000;
                if (hit(s_axi_araddr, irq_status_pkg::IDX_STATUS))
                    rdata_q[7:0] <= status;
                else if (hit(s_axi_araddr, irq_status_pkg::IDX_MASK))
                    rdata_q[7:0] <= interrupt_enable_mask_q;
                else if (hit(s_axi_araddr, irq_status_pkg::IDX_CONTROL)) begin
                    rdata_q[irq_status_pkg::C_TXEN] <= txen_q;
                    rdata_q[irq_status_pkg::C_LEEN] <= le_en_q;
                    rdata_q[irq_status_pkg::C_CREN] <= cr_en_q;
                    rdata_q[irq_status_pkg::C_TEEN] <= te_en_q;
                    rdata_q[irq_status_pkg::C_DISC] <= discard_q;
                    rdata_q[irq_status_pkg::C_THR_LO +: irq_status_pkg::THR_W] <= early_receive_threshold_q;
                end else if (hit(s_axi_araddr, irq_status_pkg::IDX_PH_STAT)) begin
                    rdata_q[0] <= tx_success_q;
                    rdata_q[irq_status_pkg::P_CAUSE +: 5] <= cause_q;
                    rdata_q[irq_status_pkg::P_PEND +: 3]  <= {txerr_pend_q, roll_pend_q, link_pend_q};
                end else if (hit(s_axi_araddr, irq_status_pkg::IDX_PHY_ST))
                    rdata_q[irq_status_pkg::PHY_BITS-1:0] <= phy_lat_q;
                else if (hit(s_axi_araddr, irq_status_pkg::IDX_COUNTER))
                    rdata_q[15:0] <= counter_value;
                else
                    rresp_q <= irq_status_pkg::RESP_DECERR;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // mask and control registers
    // ------------------------------------------------------------
    // mask in lane 0: byte or word write lands
    always_ff @(posedge aclk) begin
        if (!aresetn)
            interrupt_enable_mask_q <= irq_status_pkg::MASK_RST;
        else if (wr_go & hit(s_axi_awaddr, irq_status_pkg::IDX_MASK) & s_axi_wstrb[0])
            interrupt_enable_mask_q <= s_axi_wdata[7:0];
    end

    // exception enables and early receive threshold
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            le_en_q <= 1'b0;
            cr_en_q <= 1'b0;
            te_en_q <= 1'b0;
            early_receive_threshold_q <= irq_status_pkg::THR_RST;
        end else if (wr_ctl) begin
            le_en_q <= s_axi_wdata[irq_status_pkg::C_LEEN];
            cr_en_q <= s_axi_wdata[irq_status_pkg::C_CREN];
            te_en_q <= s_axi_wdata[irq_status_pkg::C_TEEN];
            early_receive_threshold_q <= s_axi_wdata[irq_status_pkg::C_THR_LO +: irq_status_pkg::THR_W];
        end
    end

    // transmit enable: a fatal error beats software
    always_ff @(posedge aclk) begin
        if (!aresetn)
            txen_q <= 1'b0;
        else if (tx_fatal)
            txen_q <= 1'b0;
        else if (wr_ctl)
            txen_q <= s_axi_wdata[irq_status_pkg::C_TXEN];
    end

    // transmit success and recorded fatal cause
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_success_q <= 1'b0;
            cause_q      <= '0;
        end else if (tx_fatal) begin
            tx_success_q <= 1'b0;
            cause_q      <= tx_cause;
        end else if (tx_done)
            tx_success_q <= 1'b1;
    end

    // discard request, self clearing
    always_ff @(posedge aclk) begin
        if (!aresetn)
            discard_q <= 1'b0;
        else if (wr_ctl & s_axi_wdata[irq_status_pkg::C_DISC])
            discard_q <= 1'b1;
        else if (rx_ev.frame_end | ~rx_ev.active)
            discard_q <= 1'b0;
    end

    // ------------------------------------------------------------
    // protocol handler exception sources
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link_pend_q  <= 1'b0;
            roll_pend_q  <= 1'b0;
            txerr_pend_q <= 1'b0;
        end else begin
            if (link_transition & le_en_q)
                link_pend_q <= 1'b1;
            else if (wr_ctl & ~s_axi_wdata[irq_status_pkg::C_LEEN])
                link_pend_q <= 1'b0;
            if (counter_rollover & cr_en_q)
                roll_pend_q <= 1'b1;
            else if (rd_cnt)
                roll_pend_q <= 1'b0;
            if (tx_fatal & te_en_q)
                txerr_pend_q <= 1'b1;
            else if (wr_ctl & s_axi_wdata[irq_status_pkg::C_TXEN])
                txerr_pend_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // phy status change latch
    // ------------------------------------------------------------
    // a held bit keeps its value until read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phy_lat_q  <= '0;
            phy_held_q <= '0;
        end else begin
            for (int i = 0; i < irq_status_pkg::PHY_BITS; i++) begin
                if (rd_phy & phy_held_q[i]) begin
                    phy_lat_q[i]  <= phy_status[i];
                    phy_held_q[i] <= 1'b0;
                end else if (~phy_held_q[i] & (phy_status[i] != phy_lat_q[i])) begin
                    phy_lat_q[i]  <= phy_status[i];
                    phy_held_q[i] <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // acknowledgeable latched flags (set wins over acknowledge)
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phy_mgmt_change_irq_q <= 1'b0;
            early_receive_irq_q   <= 1'b0;
            receive_overrun_irq_q <= 1'b0;
            tx_empty_irq_q        <= 1'b1;
            tx_empty_prev_q       <= 1'b1;
        end else begin
            tx_empty_prev_q <= tx_queue_empty;
            if (|(~phy_held_q & (phy_status ^ phy_lat_q)))
                phy_mgmt_change_irq_q <= 1'b1;
            else if (ack[irq_status_pkg::B_MGMT])
                phy_mgmt_change_irq_q <= 1'b0;
            if (early_hit)
                early_receive_irq_q <= 1'b1;
            else if (ack[irq_status_pkg::B_ERCV])
                early_receive_irq_q <= 1'b0;
            if (rx_ev.abort_alloc | rx_ev.oversize | (discard_q & rx_ev.active & rx_ev.frame_end))
                receive_overrun_irq_q <= 1'b1;
            else if (ack[irq_status_pkg::B_OVRN])
                receive_overrun_irq_q <= 1'b0;
            if (tx_queue_empty & ~tx_empty_prev_q)
                tx_empty_irq_q <= 1'b1;
            else if (ack[irq_status_pkg::B_TXEMP])
                tx_empty_irq_q <= 1'b0;
        end
    end

    // failed flag high from reset until an allocation succeeds
    always_ff @(posedge aclk) begin
        if (!aresetn)
            alloc_failed_q <= 1'b1;
        else if (alloc_request | alloc_fail)
            alloc_failed_q <= 1'b1;
        else if (alloc_ok)
            alloc_failed_q <= 1'b0;
    end

    // completion acknowledge pops the queue head
    always_ff @(posedge aclk) begin
        if (!aresetn)
            pop_q <= 1'b0;
        else
            pop_q <= ack[irq_status_pkg::B_TXCMP] & ~completion_queue_empty;
    end

    // ------------------------------------------------------------
    // interrupt output
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn)
            irq_q <= 1'b0;
        else
            irq_q <= |(status & interrupt_enable_mask_q);
    end

    assign s_axi_awready        = awready_q;
    assign s_axi_wready         = awready_q;
    assign s_axi_bvalid         = bvalid_q;
    assign s_axi_bresp          = bresp_q;
    assign s_axi_arready        = arready_q;
    assign s_axi_rvalid         = rvalid_q;
    assign s_axi_rresp          = rresp_q;
    assign s_axi_rdata          = rdata_q;
    assign irq                  = irq_q;
    assign transmit_enable_flag = txen_q;
    assign receive_discard      = discard_q;
    assign completion_pop       = pop_q;

endmodule

// [irq_status_pkg.sv]
// constants and carrier types shared by the interrupt status block
// assumes one register per aligned 32-bit word
package irq_status_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_STATUS  = 6'h0c; // status on read, acknowledge on write
    localparam logic [5:0] IDX_MASK    = 6'h0d;
    localparam logic [5:0] IDX_CONTROL = 6'h10;
    localparam logic [5:0] IDX_PH_STAT = 6'h11;
    localparam logic [5:0] IDX_PHY_ST  = 6'h12;
    localparam logic [5:0] IDX_COUNTER = 6'h13;

    // ------------------------------------------------------------
    // status, mask and acknowledge bit positions
    // ------------------------------------------------------------
    localparam int B_RCV    = 0;
    localparam int B_TXCMP  = 1;
    localparam int B_TXEMP  = 2;
    localparam int B_ALLOC  = 3;
    localparam int B_OVRN   = 4;
    localparam int B_PH     = 5;
    localparam int B_ERCV   = 6;
    localparam int B_MGMT   = 7;

    // control register fields
    localparam int C_TXEN   = 0;
    localparam int C_LEEN   = 1;
    localparam int C_CREN   = 2;
    localparam int C_TEEN   = 3;
    localparam int C_DISC   = 4;
    localparam int C_THR_LO = 8;
    localparam int THR_W    = 5;

    // protocol handler status fields
    localparam int P_CAUSE  = 1;
    localparam int P_PEND   = 8;

    // ------------------------------------------------------------
    // reset values and scales
    // ------------------------------------------------------------
    localparam logic [7:0]       MASK_RST    = 8'h00;
    localparam logic [THR_W-1:0] THR_RST     = 5'h1f;
    localparam int               THR_SHIFT   = 6;     // threshold counts 64-byte blocks
    localparam int               RX_BYTES_W  = 12;
    localparam int               PHY_BITS    = 9;
    localparam logic [1:0]       RESP_OKAY   = 2'h0;
    localparam logic [1:0]       RESP_DECERR = 2'h3;

    // receive side events
    typedef struct packed {
        logic                  active;      // frame being stored
        logic                  frame_end;   // pulse, end of frame
        logic                  abort_alloc; // pulse, allocation failed
        logic                  oversize;    // pulse, frame over 2k bytes
        logic [RX_BYTES_W-1:0] bytes;       // bytes stored so far
    } rx_ev_t;

    // transmit fatal error causes
    typedef struct packed {
        logic underrun;
        logic sqe_err;
        logic carrier_lost;
        logic late_collision;
        logic excess_collisions;
    } tx_cause_t;

endpackage

// [irq_status_properties.sv]
// checker of irq_status bus answers and controls
// assumes irq_status with an 8-bit address
`timescale 1ns/1ps
module irq_status_properties (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    // device side
    input wire logic        tx_fatal,
    input wire logic        transmit_enable_flag,
    input wire logic        completion_pop
);
    // ------------------------------------------------------------
    // bus and control checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_write_answered: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready
        |=> s_axi_awready && s_axi_bvalid) else $error("write not answered");
    a_read_answered: assert property (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready
        |=> s_axi_arready && s_axi_rvalid) else $error("read not answered");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    a_ready_pair: assert property (s_axi_awready == s_axi_wready)
        else $error("address and data ready differ");
    a_fatal_stops_tx: assert property (tx_fatal |=> !transmit_enable_flag)
        else $error("transmit enable kept after fatal error");
    a_pop_single: assert property (completion_pop |=> !completion_pop)
        else $error("completion pop longer than one cycle");
    a_unmapped_read: assert property (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready && s_axi_araddr == 8'h00
        |=> s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0) else $error("unmapped read answered");
endmodule
bind irq_status irq_status_properties irq_status_properties_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_wvalid,
    .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_araddr,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .tx_fatal, .transmit_enable_flag,
    .completion_pop);

// [irq_status_test.sv]
// self-checking bench of irq_status
// assumes the bound checker and a single aclk domain
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; $display("unexpected at %0t: mismatch", $time); end end
module irq_status_test;
    // ------------------------------------------------------------
    // stimulus and observed ports
    // ------------------------------------------------------------
    logic        aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '1;
    logic        s_axi_arvalid = '0, s_axi_rready = '1, link_transition = '0, counter_rollover = '0;
    logic        tx_done = '0, tx_fatal = '0, alloc_request = '0, alloc_ok = '0, alloc_fail = '0;
    logic        tx_queue_empty = '1, completion_queue_empty = '1, receive_queue_empty = '1;
    logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, v, exp_q[$], msk_q[$];
    logic [3:0]  s_axi_wstrb = '0;
    logic [8:0]  phy_status = '0;
    logic [15:0] counter_value = '0;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic        transmit_enable_flag, receive_discard, completion_pop;
    irq_status_pkg::rx_ev_t    rx_ev = '0;
    irq_status_pkg::tx_cause_t tx_cause = '0;
    int          err_count = 0, check_count = 0, pops = 0;
    irq_status irq_status_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .phy_status,
        .rx_ev, .link_transition, .counter_rollover, .counter_value, .tx_done, .tx_fatal, .tx_cause,
        .alloc_request, .alloc_ok, .alloc_fail, .tx_queue_empty, .completion_queue_empty,
        .receive_queue_empty, .irq, .transmit_enable_flag, .receive_discard, .completion_pop);
    // clock, pop counter and read-answer monitor
    always #50 aclk = ~aclk;
    always @(posedge aclk) if (completion_pop === 1'b1) pops++;
    always @(posedge aclk) if (s_axi_rvalid === 1'b1 && exp_q.size() > 0) `CHK(s_axi_rdata & msk_q.pop_front(), exp_q.pop_front())
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // write, address and data together
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid} <= {a, d, s, 2'h3};
        do @(posedge aclk); while (s_axi_awready !== 1'b1);
        {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
    endtask
    // read, noting the expectation first
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= '0;
    endtask
    task automatic complete_run;
        $display("errors %0d checks %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #1000000;
        err_count++;
        complete_run();
    end
    // main sequence
    initial begin
        void'($urandom(32'h5842));
        tick(10);
        aresetn <= '1;
        rd(8'h34, 32'h0, 32'hff);
        rd(8'h30, 32'h04, 32'hff);
        v = $urandom & 32'hff;
        wr(8'h34, v, 4'h1);
        rd(8'h34, v, 32'hff);
        wr(8'h34, ~v, 4'h0);
        rd(8'h34, v, 32'hff);
        wr(8'h34, 32'h01, 4'h1);
        receive_queue_empty <= '0;
        tick(3);
        `CHK(irq, 1'b1)
        wr(8'h34, 32'h0, 4'h1);
        tick(3);
        `CHK(irq, 1'b0)
        rd(8'h30, 32'h05, 32'hff);
        receive_queue_empty <= '1;
        tick(2);
        rd(8'h30, 32'h04, 32'hff);
        wr(8'h30, 32'h04, 4'h1);
        rd(8'h30, 32'h0, 32'h04);
        tx_queue_empty <= '0;
        wr(8'h34, 32'h04, 4'h1);
        tx_queue_empty <= '1;
        tick(2);
        rd(8'h30, 32'h04, 32'h04);
        `CHK(irq, 1'b1)
        rx_ev.abort_alloc <= '1;
        tick(1);
        rx_ev.abort_alloc <= '0;
        rd(8'h30, 32'h10, 32'h10);
        wr(8'h30, 32'h10, 4'h1);
        rd(8'h30, 32'h0, 32'h10);
        alloc_ok <= '1;
        tick(1);
        alloc_ok <= '0;
        rd(8'h30, 32'h08, 32'h08);
        alloc_request <= '1;
        tick(1);
        alloc_request <= '0;
        rd(8'h30, 32'h0, 32'h08);
        v = ($urandom | 32'h1) & 32'h1ff;
        phy_status <= v[8:0];
        tick(2);
        rd(8'h30, 32'h80, 32'h80);
        rd(8'h48, v, 32'h1ff);
        wr(8'h30, 32'h80, 4'h1);
        rd(8'h30, 32'h0, 32'h80);
        completion_queue_empty <= '0;
        tick(2);
        rd(8'h30, 32'h02, 32'h02);
        wr(8'h30, 32'h02, 4'h1);
        tick(2);
        `CHK(pops, 1)
        completion_queue_empty <= '1;
        wr(8'h40, 32'h0109, 4'hf);
        rx_ev <= '{1'b1, 1'b0, 1'b0, 1'b0, 12'h040};
        rd(8'h30, 32'h0, 32'h40);
        rx_ev.bytes <= 12'h041;
        tick(2);
        rd(8'h30, 32'h40, 32'h40);
        rx_ev <= '0;
        {tx_cause.underrun, tx_fatal} <= 2'h3;
        tick(1);
        tx_fatal <= '0;
        tick(2);
        `CHK(transmit_enable_flag, 1'b0)
        rd(8'h30, 32'h20, 32'h20);
        rd(8'h44, 32'h420, 32'h43f);
        wr(8'h40, 32'h0109, 4'hf);
        rd(8'h30, 32'h0, 32'h20);
        rd(8'h00, 32'h0, 32'hffffffff);
        complete_run();
    end
endmodule
